// ---- stm_cmp.sv ----
`include "stm_map.svh"
module stm_cmp
	import stm_pkg::*;
(
	input wire stm_count_t count,
	input wire stm_byte_t cmp_p,
	input wire stm_count_t cmp_a,
	output logic hit_a,
	output logic hit_p,
	output logic duty_a,
	output logic duty_p
);
	// Value the counter takes on the coming tick
	wire stm_wide_t step = {1'b0, count} + `STM_CNT_ONE;
	wire p_is_ovf = (cmp_p == `STM_CMPP_OVF);
	wire p_hit_bits = (step[15:8] == cmp_p) & (step[7:0] == 8'h00);

	// Compare A sees all sixteen bits
	assign hit_a = (step == {1'b0, cmp_a});
	// Compare P sees only the top byte; zero means overflow [RULE3] [RULE4]
	assign hit_p = p_is_ovf ? step[16] : p_hit_bits;
	// Duty windows; a duty at or past the period stays active [RULE17]
	assign duty_a = (count < cmp_a);
	assign duty_p = p_is_ovf | (count[15:8] < cmp_p);
endmodule // stm_cmp

// ---- stm_load.sv ----
module stm_load
	import stm_pkg::*;
(
	input wire logic pin,
	input wire logic en,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-down load: an undriven pin reads low, never the last level
	assign line = en ? pin : 1'b0;
endmodule // stm_load

// ---- stm_map.svh ----
`ifndef STM_MAP_SVH
`define STM_MAP_SVH

// Register offsets on the byte-wide register port
`define STM_OFS_CTRL0 3'h0
`define STM_OFS_CTRL1 3'h1
`define STM_OFS_CNT_LO 3'h2
`define STM_OFS_CNT_HI 3'h3
`define STM_OFS_CMPA_LO 3'h4
`define STM_OFS_CMPA_HI 3'h5
`define STM_OFS_CMPP 3'h6
`define STM_OFS_FLAGS 3'h7

// Control 0 field positions
`define STM_BIT_TIMER_ON 3

// Control 1 field positions
`define STM_BIT_MODE_HI 7
`define STM_BIT_MODE_LO 6
`define STM_BIT_ACT_HI 5
`define STM_BIT_ACT_LO 4
`define STM_BIT_INIT_LVL 3
`define STM_BIT_INVERT 2
`define STM_BIT_SWAP 1
`define STM_BIT_CCLR 0

// Flag register field positions
`define STM_BIT_FLAG_A 0
`define STM_BIT_FLAG_P 1

// Mode select codes
`define STM_MODE_CMP 2'h0
`define STM_MODE_CAPT 2'h1
`define STM_MODE_PWM 2'h2
`define STM_MODE_TMR 2'h3

// Output action codes, compare-match mode
`define STM_ACT_NONE 2'h0
`define STM_ACT_LOW 2'h1
`define STM_ACT_HIGH 2'h2
`define STM_ACT_TOGGLE 2'h3

// Output action codes, PWM mode
`define STM_PWM_FORCE_OFF 2'h0
`define STM_PWM_FORCE_ON 2'h1
`define STM_PWM_WAVE 2'h2
`define STM_PWM_PULSE 2'h3

// Reset values and special counts
`define STM_RST_BYTE 8'h00
`define STM_RST_COUNT 16'h0000
`define STM_RST_FLAGS 2'h0
`define STM_CMPP_OVF 8'h00
`define STM_CNT_ONE 17'h00001

`endif

// ---- stm_pkg.sv ----
package stm_pkg;
	// One register byte
	typedef logic [7:0] stm_byte_t;
	// The 16-bit counter and compare A value
	typedef logic [15:0] stm_count_t;
	// Counter plus carry, for overflow detection
	typedef logic [16:0] stm_wide_t;
	// Two-bit mode select and output action fields
	typedef logic [1:0] stm_field_t;
	// Register port address
	typedef logic [2:0] stm_addr_t;
endpackage

// ---- stm_props.sv ----
module stm_props
	import stm_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire stm_addr_t REG_ADDR,
	input wire stm_byte_t REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire stm_byte_t REG_RDATA,
	input wire logic TIMER_TICK,
	input wire logic TIMER_OUTPUT_PIN,
	input wire logic TIMER_OUTPUT_EN
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shadow of what software wrote
	logic on_m;
	stm_byte_t c1_m, alo_m, ahi_m, p_m;
	logic rd_q, tick_q;
	stm_addr_t ra_q;
	// Saturating ages: setup writes, tick edges, timer-on restart
	logic [2:0] quiet;
	logic [3:0] age;
	logic [1:0] fresh;
	wire rise = TIMER_TICK && !tick_q;
	wire cfg_wr = REG_WR && REG_ADDR[2:1] != 2'b01 && REG_ADDR != 3'h7;
	wire on_rise = REG_WR && REG_ADDR == 3'h0 && REG_WDATA[3] && !on_m;
	wire [2:0] next_quiet = cfg_wr ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
	wire [3:0] next_age = rise ? 4'h0 : age + {3'h0, age != 4'hF};
	wire [1:0] next_fresh = on_rise ? 2'h1 : rise ? 2'h0 : fresh + {1'b0, fresh[1] ^ fresh[0]};
	wire [15:0] a_m = {ahi_m, alo_m};
	wire [15:0] p_span = {p_m, 8'h00};
	// Pin level while the waveform is active
	wire lvl = c1_m[3] ^ c1_m[2];
	wire wave = on_m && c1_m[7:4] == 4'hA;
	wire full = c1_m[1] ? (p_m == 8'h00 || p_span >= a_m) : (p_m != 8'h00 && a_m >= p_span);
	wire [7:0] exp_rd = ra_q == 3'h0 ? {4'h0, on_m, 3'h0} : ra_q == 3'h1 ? c1_m :
		ra_q == 3'h4 ? alo_m : ra_q == 3'h5 ? ahi_m : p_m;
	// Flags and counter excluded: they move by themselves
	wire rb = rd_q && ra_q[2:1] != 2'b01 && ra_q != 3'h7;
	wire cnt_rd = rd_q && ra_q[2:1] == 2'b01;

	// Shadow registers and ages
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			{on_m, c1_m, alo_m, ahi_m, p_m, rd_q, tick_q, ra_q} <= '0;
			{quiet, age, fresh} <= '0;
		end else begin
			if (REG_WR && REG_ADDR == 3'h0) on_m <= REG_WDATA[3];
			if (REG_WR && REG_ADDR == 3'h1) c1_m <= REG_WDATA;
			if (REG_WR && REG_ADDR == 3'h4) alo_m <= REG_WDATA;
			if (REG_WR && REG_ADDR == 3'h5) ahi_m <= REG_WDATA;
			if (REG_WR && REG_ADDR == 3'h6) p_m <= REG_WDATA;
			{rd_q, ra_q, tick_q} <= {REG_RD, REG_ADDR, TIMER_TICK};
			{quiet, age, fresh} <= {next_quiet, next_age, next_fresh};
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);

	rd_idle_zero_a:
		assert property (!REG_RD |=> REG_RDATA == 8'h00) else $error("read data not idle");
	reg_readback_a:
		assert property (rb |-> REG_RDATA == exp_rd) else $error("readback differs");
	en_mode_a:
		assert property (quiet == 3'h7 |-> TIMER_OUTPUT_EN == !c1_m[6]) else $error("pin enable");
	cmp_pin_cause_a:
		assert property (c1_m[7:6] == 2'b00 && $changed(TIMER_OUTPUT_PIN) |->
			quiet != 3'h7 || age < 4'hC) else $error("pin moved without cause");
	restart_level_a:
		assert property (on_rise && c1_m[7:6] == 2'b00 |-> ##[1:3] TIMER_OUTPUT_PIN == lvl)
		else $error("restart level");
	pwm_force_a:
		assert property (quiet == 3'h7 && on_m && c1_m[7:5] == 3'b100 |->
			TIMER_OUTPUT_PIN == (lvl ^ !c1_m[4])) else $error("forced level");
	pwm_full_a:
		assert property (quiet == 3'h7 && wave && full |-> TIMER_OUTPUT_PIN == lvl)
		else $error("full duty");
	cnt_restart_a:
		assert property (cnt_rd && fresh == 2'h3 |-> REG_RDATA == 8'h00) else $error("restart count");

	cover property (wave && TIMER_OUTPUT_PIN);
	cover property (on_rise);
	cover property (cnt_rd && fresh == 2'h3);
endmodule // stm_props

bind stm_timer stm_props u_props (.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.TIMER_TICK(TIMER_TICK), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
	.TIMER_OUTPUT_EN(TIMER_OUTPUT_EN));

// ---- stm_sync.sv ----
module stm_sync
	import stm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic rise
);
	logic s1; // First stage, read only by the second
	logic s2; // Second stage
	logic s3; // Third stage
	logic level; // Accepted level
	wire agree = (s2 == s3);

	// Three-stage synchroniser with a filtered level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			// A change counts only once two stages agree
			if (agree) begin
				level <= s3;
			end
		end
	end

	// One-cycle pulse on an accepted rising edge
	assign rise = agree & s3 & ~level;
endmodule // stm_sync

// ---- stm_tb.sv ----
module tb
	import stm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK = 1'b0;
	logic RST_B = 1'b0;
	stm_addr_t REG_ADDR = 3'h0;
	stm_byte_t REG_WDATA = 8'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic TIMER_TICK = 1'b0;
	stm_byte_t REG_RDATA;
	logic TIMER_OUTPUT_PIN, TIMER_OUTPUT_EN, line;
	int err_count = 0;
	int checks_done = 0;

	always #5 REF_CLK = ~REF_CLK;

	stm_timer dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TIMER_TICK(TIMER_TICK),
		.TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_OUTPUT_EN(TIMER_OUTPUT_EN));
	stm_load ld (.pin(TIMER_OUTPUT_PIN), .en(TIMER_OUTPUT_EN), .line(line));

	task automatic chk(input string w, input stm_count_t e, input stm_count_t s);
		checks_done++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", w, e, s);
			err_count++;
		end
	endtask
	// A gap cycle follows each strobe so it is never reassigned in one step
	task automatic wr(input stm_addr_t a, input stm_byte_t d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task automatic rd(input stm_addr_t a, input stm_byte_t e, input string w);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1;
		chk(w, {8'h00, e}, {8'h00, REG_RDATA});
		@(posedge REF_CLK);
	endtask
	// Pin checked through the load, then back onto the edge
	task automatic pin(input logic e, input string w);
		#1;
		chk(w, {15'h0, e}, {15'h0, line});
		@(posedge REF_CLK);
	endtask
	// Tick pin high and low four cycles each, past the input filter
	task automatic tick(input int n);
		repeat (n) begin
			TIMER_TICK <= 1'b1;
			repeat (4) @(posedge REF_CLK);
			TIMER_TICK <= 1'b0;
			repeat (4) @(posedge REF_CLK);
		end
	endtask
	// Timer off, program, clear flags, then restart from zero
	task automatic setup(input stm_byte_t c, input stm_count_t a, input stm_byte_t p);
		wr(3'h0, 8'h00);
		wr(3'h1, c);
		wr(3'h4, a[7:0]);
		wr(3'h5, a[15:8]);
		wr(3'h6, p);
		wr(3'h7, 8'h03);
		wr(3'h0, 8'h08);
	endtask
	task automatic t_regs();
		for (int a = 2; a < 7; a++) begin
			rd(a[2:0], 8'h00, "reset_value");
		end
		wr(3'h4, 8'hA5);
		wr(3'h5, 8'h5A);
		wr(3'h2, 8'hFF);
		wr(3'h0, 8'hF7);
		rd(3'h4, 8'hA5, "cmpa_lo");
		rd(3'h5, 8'h5A, "cmpa_hi");
		rd(3'h2, 8'h00, "cnt_lo_ro");
		rd(3'h0, 8'h00, "ctrl0");
	endtask
	// Every action code from both initial levels, clear on compare A
	task automatic t_cmp();
		logic e;
		for (int i = 0; i < 8; i++) begin
			setup({2'b00, i[1:0], i[2], 3'b001}, 16'h0003, 8'h00);
			pin(i[2], "restart_pin");
			tick(3);
			e = (i[0] == i[1]) ? i[2] ^ i[0] : i[1];
			pin(e, "cmp_pin");
			rd(3'h7, 8'h01, "flags_a_only");
			tick(1);
			rd(3'h2, 8'h01, "cnt_after_clear");
		end
	endtask
	task automatic t_cmpp();
		setup(8'h00, 16'h0003, 8'h01);
		tick(256);
		rd(3'h7, 8'h03, "flags_both");
		rd(3'h3, 8'h00, "cnt_hi_clear");
	endtask
	task automatic t_tmr();
		setup(8'hF9, 16'h0003, 8'h00);
		tick(3);
		pin(1'b0, "tmr_pin_free");
		rd(3'h7, 8'h01, "tmr_flags");
	endtask
	task automatic t_force();
		setup(8'h8C, 16'h0010, 8'h01);
		rd(3'h2, 8'h00, "cnt_restart");
		tick(2);
		pin(1'b1, "force_off");
		rd(3'h2, 8'h02, "forced_count");
		setup(8'h90, 16'h0010, 8'h01);
		tick(2);
		pin(1'b0, "force_on");
	endtask
	// Capture mode owns no pin and ignores the clear select; single
	// pulse is not built and holds the inactive level
	task automatic t_capt();
		setup(8'h59, 16'h0002, 8'h00);
		tick(2);
		pin(1'b0, "capt_pin_free");
		rd(3'h2, 8'h02, "capt_no_a_clear");
		setup(8'hB8, 16'h0010, 8'h01);
		tick(2);
		pin(1'b0, "pulse_idle");
	endtask
	// Count ticks after which the pin is high over n ticks
	task automatic t_pwm(input stm_byte_t c, input stm_count_t a, input stm_byte_t p,
		input int n, input int e);
		int hi;
		hi = 0;
		setup(c, a, p);
		repeat (n) begin
			tick(1);
			hi += line;
		end
		chk("pwm_high", e[15:0], hi[15:0]);
	endtask
	task automatic summarize();
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge REF_CLK);
		RST_B <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		t_regs();
		t_cmp();
		t_cmpp();
		t_tmr();
		t_force();
		t_capt();
		t_pwm(8'hA9, 16'd64, 8'd1, 256, 64);
		rd(3'h7, 8'h03, "pwm_flags");
		t_pwm(8'hA0, 16'd64, 8'd1, 256, 192);
		t_pwm(8'hA8, 16'd300, 8'd1, 256, 256);
		t_pwm(8'hAA, 16'd200, 8'd0, 200, 200);
		t_pwm(8'hAA, 16'd300, 8'd1, 300, 256);
		summarize();
	end
	// Watchdog: a hang counts as a mismatch
	initial begin
		#500000;
		err_count++;
		summarize();
	end
endmodule // tb

// ---- stm_timer.sv ----
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "stm_map.svh"

//
// Contract
// RULE1 - Counter readable as two read-only bytes
// RULE2 - Compare A stored as two RW bytes
// RULE3 - Compare P matches counter top byte only
// RULE4 - Compare P zero means 65536 period
// RULE5 - Mode 00 selects compare-match output
// RULE6 - Clear select low: clear on P, both flags
// RULE7 - Clear select high: clear on A, A flag only
// RULE8 - Software avoids compare A zero here
// RULE9 - Pin changes only on compare A match
// RULE10 - Action field sets high, low or toggle
// RULE11 - Timer-on rise restores initial pin level
// RULE12 - Mode 11 compares but leaves pin undriven
// RULE13 - Software picks mode 10, action 10
// RULE14 - Clear select ignored in PWM mode
// RULE15 - Swap zero: P period, A duty
// RULE16 - Swap one: A period, P duty
// RULE17 - Duty at or past period gives full duty
// RULE18 - PWM raises both flags on matches
// RULE19 - Initial level picks polarity, invert flips pin
// RULE20 - PWM keeps running while output forced
// RULE21 - Compare action codes none/low/high/toggle
// RULE22 - PWM action codes off/on/wave/pulse; code 3 builds no pulse here and holds the inactive level
// RULE23 - Timer-on rise clears count, fall holds it
// RULE24 - Counter steps per tick and wraps
module stm_timer
	import stm_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire stm_addr_t REG_ADDR,
	input wire stm_byte_t REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output stm_byte_t REG_RDATA,
	input wire logic TIMER_TICK,
	output logic TIMER_OUTPUT_PIN,
	output logic TIMER_OUTPUT_EN
);

	// Register address decode, shared by writes and reads
	function automatic logic reg_sel(input stm_addr_t addr, input stm_addr_t ofs);
		reg_sel = (addr == ofs);
	endfunction

	// Reset release stages
	logic rst_meta_n; // First stage of the reset release
	logic rst_n; // Released reset used by the rest of the block

	// Software state
	logic timer_on; // Counter enable
	stm_byte_t ctrl1; // Mode, action, polarity and clear fields
	stm_count_t count; // The 16-bit up counter
	stm_count_t cmp_a; // Compare A value
	stm_byte_t cmp_p; // Compare P value
	logic flag_a; // Sticky compare A flag
	logic flag_p; // Sticky compare P flag
	logic cmp_state; // Pin level kept by compare-match mode
	stm_byte_t rdata; // Read data, valid one cycle after a read

	// Next values
	stm_count_t next_count;
	logic next_flag_a;
	logic next_flag_p;
	logic next_cmp_state;
	logic next_pin;
	logic next_pin_en;

	// Timer clock tick, already a pulse
	logic tick_rise;

	// Comparator results
	logic hit_a; // Counter about to reach compare A
	logic hit_p; // Counter about to reach compare P or overflow
	logic duty_a; // Inside the compare A duty window
	logic duty_p; // Inside the compare P duty window

	// Release the asynchronous reset through two flops so that
	// no flop sees the release close to a clock edge
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// The timer clock arrives from outside and is synchronised
	stm_sync u_tick_sync (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.async_in(TIMER_TICK),
		.rise(tick_rise)
	);

	// Both comparators look at the same counter
	stm_cmp u_cmp (
		.count(count),
		.cmp_p(cmp_p),
		.cmp_a(cmp_a),
		.hit_a(hit_a),
		.hit_p(hit_p),
		.duty_a(duty_a),
		.duty_p(duty_p)
	);

	// Write strobes per register
	wire wr_ctrl0 = REG_WR & reg_sel(REG_ADDR, `STM_OFS_CTRL0);
	wire wr_ctrl1 = REG_WR & reg_sel(REG_ADDR, `STM_OFS_CTRL1);
	wire wr_cmpa_lo = REG_WR & reg_sel(REG_ADDR, `STM_OFS_CMPA_LO);
	wire wr_cmpa_hi = REG_WR & reg_sel(REG_ADDR, `STM_OFS_CMPA_HI);
	wire wr_cmpp = REG_WR & reg_sel(REG_ADDR, `STM_OFS_CMPP);
	wire wr_flags = REG_WR & reg_sel(REG_ADDR, `STM_OFS_FLAGS);

	// Control fields
	wire stm_field_t mode = ctrl1[`STM_BIT_MODE_HI:`STM_BIT_MODE_LO];
	wire stm_field_t action = ctrl1[`STM_BIT_ACT_HI:`STM_BIT_ACT_LO];
	wire init_lvl = ctrl1[`STM_BIT_INIT_LVL];
	wire invert = ctrl1[`STM_BIT_INVERT];
	wire swap = ctrl1[`STM_BIT_SWAP];
	wire cclr = ctrl1[`STM_BIT_CCLR];

	// Mode decode
	wire in_cmp = (mode == `STM_MODE_CMP); // [RULE5]
	wire in_pwm = (mode == `STM_MODE_PWM);
	wire in_capt = (mode == `STM_MODE_CAPT);
	// Mode 11 counts like mode 00 but owns no pin [RULE12]
	wire in_tmr = (mode == `STM_MODE_TMR);

	// A write that turns the timer on from off
	wire on_rise = wr_ctrl0 & REG_WDATA[`STM_BIT_TIMER_ON] & ~timer_on;

	// Counting happens only while enabled, one step per tick
	wire tick_ok = timer_on & tick_rise;

	// Clear source: PWM ignores the clear select and follows swap;
	// capture is out of scope here and simply clears on compare P
	wire clr_on_a = in_pwm ? swap : (~in_capt & cclr); // [RULE14] [RULE7] [RULE16]
	wire clr_on_p = ~clr_on_a; // [RULE6] [RULE15]

	// Counter clear caused by a match on this tick
	wire match_clear = tick_ok & ((clr_on_a & hit_a) | (clr_on_p & hit_p));

	// Match events
	wire ev_a = tick_ok & hit_a; // [RULE18]
	// With clear on A in modes 00 and 11 no compare P event is raised;
	// PWM and capture ignore the clear select
	wire ev_p = tick_ok & hit_p & ~((in_cmp | in_tmr) & cclr); // [RULE7] [RULE12] [RULE18]

	// Flag clear requests, write one to clear
	wire clr_a = wr_flags & REG_WDATA[`STM_BIT_FLAG_A];
	wire clr_p = wr_flags & REG_WDATA[`STM_BIT_FLAG_P];

	// Counter next value: the enable rise wins, then a match clear,
	// then the increment; the increment wraps on its own
	always_comb begin
		next_count = count;
		if (on_rise) begin
			next_count = `STM_RST_COUNT; // [RULE23]
		end else if (match_clear) begin
			next_count = `STM_RST_COUNT; // [RULE6] [RULE7] [RULE15] [RULE16]
		end else if (tick_ok) begin
			next_count = count + 16'h0001; // [RULE24]
		end
	end

	// Sticky flags; an event in the clearing cycle is kept
	assign next_flag_a = ev_a | (flag_a & ~clr_a);
	assign next_flag_p = ev_p | (flag_p & ~clr_p);

	// Compare-match pin level. The pin moves only on a timer-on rise
	// or a compare A event; a compare P event never touches it
	always_comb begin
		next_cmp_state = cmp_state;
		if (on_rise) begin
			next_cmp_state = init_lvl; // [RULE11]
		end else if (ev_a & in_cmp) begin // [RULE9]
			case (action) // [RULE10] [RULE21]
				`STM_ACT_NONE: begin
					next_cmp_state = cmp_state;
				end
				`STM_ACT_LOW: begin
					next_cmp_state = 1'b0;
				end
				`STM_ACT_HIGH: begin
					next_cmp_state = 1'b1;
				end
				`STM_ACT_TOGGLE: begin
					next_cmp_state = ~cmp_state;
				end
				default: begin
					next_cmp_state = cmp_state;
				end
			endcase
		end
	end

	// PWM duty window: compare P with swap set, else compare A.
	// A window past the period is simply never left, so full duty
	// needs no special case
	wire pwm_active = swap ? duty_p : duty_a; // [RULE15] [RULE16] [RULE17]

	// Initial level picks active high or active low
	wire pwm_wave = pwm_active ? init_lvl : ~init_lvl; // [RULE19]

	// PWM pin level from the action field. Forcing only masks the
	// pin; the counter and flags keep running underneath
	logic pwm_level;
	always_comb begin
		pwm_level = ~init_lvl;
		case (action) // [RULE22] [RULE20]
			`STM_PWM_FORCE_OFF: begin
				pwm_level = ~init_lvl;
			end
			`STM_PWM_FORCE_ON: begin
				pwm_level = init_lvl;
			end
			`STM_PWM_WAVE: begin
				pwm_level = pwm_wave; // [RULE13]
			end
			`STM_PWM_PULSE: begin
				// Single pulse is not built; hold the inactive level
				pwm_level = ~init_lvl;
			end
			default: begin
				pwm_level = ~init_lvl;
			end
		endcase
	end

	// Pin value and drive: only compare-match and PWM modes drive
	// the pin, and the invert bit applies in both [RULE19] [RULE12]
	assign next_pin = (in_pwm ? pwm_level : cmp_state) ^ invert;
	assign next_pin_en = in_cmp | in_pwm;

	// Read data selection; unmapped bits read as zero
	wire stm_byte_t ctrl0_view = {4'h0, timer_on, 3'h0};
	wire stm_byte_t flags_view = {6'h00, flag_p, flag_a};
	wire stm_byte_t rd_mux =
		reg_sel(REG_ADDR, `STM_OFS_CTRL0) ? ctrl0_view :
		reg_sel(REG_ADDR, `STM_OFS_CTRL1) ? ctrl1 :
		reg_sel(REG_ADDR, `STM_OFS_CNT_LO) ? count[7:0] : // [RULE1]
		reg_sel(REG_ADDR, `STM_OFS_CNT_HI) ? count[15:8] : // [RULE1]
		reg_sel(REG_ADDR, `STM_OFS_CMPA_LO) ? cmp_a[7:0] : // [RULE2]
		reg_sel(REG_ADDR, `STM_OFS_CMPA_HI) ? cmp_a[15:8] : // [RULE2]
		reg_sel(REG_ADDR, `STM_OFS_CMPP) ? cmp_p :
		flags_view;

	// Enable bit; turning it off just stops ticks, the count holds
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			timer_on <= 1'b0;
		end else if (wr_ctrl0) begin
			timer_on <= REG_WDATA[`STM_BIT_TIMER_ON]; // [RULE23]
		end
	end

	// Mode and output control byte
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1 <= `STM_RST_BYTE;
		end else if (wr_ctrl1) begin
			ctrl1 <= REG_WDATA;
		end
	end

	// Compare A, written byte by byte. Compare A of zero in
	// compare-match mode never matches, software must avoid it
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cmp_a <= `STM_RST_COUNT; // [RULE2]
		end else begin
			if (wr_cmpa_lo) begin
				cmp_a[7:0] <= REG_WDATA; // [RULE2] [RULE8]
			end
			if (wr_cmpa_hi) begin
				cmp_a[15:8] <= REG_WDATA; // [RULE2]
			end
		end
	end

	// Compare P byte
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cmp_p <= `STM_RST_BYTE;
		end else if (wr_cmpp) begin
			cmp_p <= REG_WDATA; // [RULE3]
		end
	end

	// Counter register, read only to software
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			count <= `STM_RST_COUNT; // [RULE1]
		end else begin
			count <= next_count;
		end
	end

	// Flags and compare-match pin level
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flag_a <= 1'b0;
			flag_p <= 1'b0;
			cmp_state <= 1'b0;
		end else begin
			flag_a <= next_flag_a;
			flag_p <= next_flag_p;
			cmp_state <= next_cmp_state;
		end
	end

	// Pin outputs from flops, one cycle behind the logic
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			TIMER_OUTPUT_PIN <= 1'b0;
			TIMER_OUTPUT_EN <= 1'b0;
		end else begin
			TIMER_OUTPUT_PIN <= next_pin;
			TIMER_OUTPUT_EN <= next_pin_en;
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `STM_RST_BYTE;
		end else if (REG_RD) begin
			rdata <= rd_mux;
		end else begin
			rdata <= `STM_RST_BYTE;
		end
	end

	assign REG_RDATA = rdata;

endmodule // stm_timer
